// *** ccd_pkg.sv ***
// Operation
// - Output stays low for low-count field plus one input cycles.
// - Output stays high for high-count field plus one input cycles.
// - Bypass bit stops the divider and passes the input clock through.
// - Clear ignore-sync obeys chip sync; set ignore-sync disregards it.
// - Force bit sets a static output level, only with ignore-sync set.
// - While bypassed the force bit has no effect.
// - Start-level bit picks the first level of the divided clock.
// - Each divider has a 4-bit phase offset field, reset to zero.
// - Channel power-down bit puts all three channel outputs in power-down.
// - Duty-cycle correction is on while its disable bit and the divider one bypass bit are both zero.
package ccd_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam int AW = 10;
	localparam logic [AW-1:0] OFS_D1_CNT = 10'h193;
	localparam logic [AW-1:0] OFS_D1_CTRL = 10'h194;
	localparam logic [AW-1:0] OFS_CH1_CFG = 10'h195;
	localparam logic [AW-1:0] OFS_D2_CNT = 10'h196;
	localparam logic [AW-1:0] OFS_D2_CTRL = 10'h197;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_D1_CNT = 8'h33;
	localparam logic [7:0] RST_D1_CTRL = 8'h00;
	localparam logic [7:0] RST_CH1_CFG = 8'h00;
	localparam logic [7:0] RST_D2_CNT = 8'h11;
	localparam logic [7:0] RST_D2_CTRL = 8'h00;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int LOW_MSB = 7;
	localparam int LOW_LSB = 4;
	localparam int HIGH_MSB = 3;
	localparam int HIGH_LSB = 0;
	localparam int BYP_BIT = 7;
	localparam int IGN_BIT = 6;
	localparam int FRC_BIT = 5;
	localparam int STH_BIT = 4;
	localparam int PH_MSB = 3;
	localparam int PH_LSB = 0;
	localparam int PD_BIT = 2;
	localparam int DCC_BIT = 0;
	localparam logic [7:0] CH_CFG_MASK = 8'h05;
	localparam int CH_OUTS = 3;
endpackage : ccd_pkg

// *** ccd_div_core.sv ***
module ccd_div_core #(
	parameter int CW = 4
) (
	input wire logic clk_sys, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic in_rise, // One divider input cycle
	input wire logic src_lvl, // Divider input clock level
	input wire logic [CW-1:0] low_cnt, // Low cycles minus one
	input wire logic [CW-1:0] high_cnt, // High cycles minus one
	input wire logic [CW-1:0] phase, // Phase offset in input cycles
	input wire logic bypass, // Pass input straight through
	input wire logic ignore_sync, // Disregard chip sync
	input wire logic force_hi, // Static level under ignore-sync
	input wire logic start_hi, // First level after start
	input wire logic sync_act, // Chip-level sync, held while high
	output logic div_out_r // Divider output
);
	typedef enum logic [1:0] {CCD_HOLD, CCD_PHASE, CCD_RUN} ccd_state_e;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (CW < 2) begin : g_bad_cw
		$error("ccd_div_core: CW must be at least 2");
	end

	ccd_state_e state_r, state_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic out_nxt;

	// Next state: bypass, then forced level, then sync hold, then counting
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		out_nxt = div_out_r;
		if (bypass) begin
			state_nxt = CCD_HOLD;
			cnt_nxt = '0;
			out_nxt = src_lvl;
		end else if (ignore_sync) begin
			state_nxt = CCD_HOLD;
			cnt_nxt = '0;
			out_nxt = force_hi;
		end else if (sync_act) begin
			state_nxt = CCD_HOLD;
			cnt_nxt = '0;
			out_nxt = start_hi;
		end else begin
			case (state_r)
				CCD_HOLD: begin
					out_nxt = start_hi;
					cnt_nxt = '0;
					state_nxt = (phase == '0) ? CCD_RUN : CCD_PHASE;
				end
				CCD_PHASE: begin
					if (in_rise) begin
						if (cnt_r == CW'(phase - 1'b1)) begin
							state_nxt = CCD_RUN;
							cnt_nxt = '0;
						end else begin
							cnt_nxt = CW'(cnt_r + 1'b1);
						end
					end
				end
				CCD_RUN: begin
					if (in_rise) begin
						if (cnt_r == (div_out_r ? high_cnt : low_cnt)) begin
							out_nxt = ~div_out_r;
							cnt_nxt = '0;
						end else begin
							cnt_nxt = CW'(cnt_r + 1'b1);
						end
					end
				end
				default: begin
					state_nxt = CCD_HOLD;
				end
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= CCD_HOLD;
			cnt_r <= '0;
			div_out_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			div_out_r <= out_nxt;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire logic free_run = !bypass && !ignore_sync && !sync_act;

	a_low_len: assert property (free_run && state_r == CCD_RUN && in_rise && !div_out_r && cnt_r == low_cnt
		|=> div_out_r) else $error("low phase did not end after low count");
	a_high_len: assert property (free_run && state_r == CCD_RUN && in_rise && div_out_r && cnt_r < high_cnt
		|=> div_out_r) else $error("high phase ended early");
	a_bypass_pass: assert property (bypass |=> div_out_r == $past(src_lvl))
		else $error("bypass does not pass input");
	a_sync_hold: assert property (!bypass && !ignore_sync && sync_act
		|=> state_r == CCD_HOLD && div_out_r == $past(start_hi)) else $error("sync did not hold divider");
	a_force_level: assert property (!bypass && ignore_sync |=> div_out_r == $past(force_hi))
		else $error("forced level wrong");
	a_bypass_noforce: assert property (bypass && ignore_sync && force_hi != src_lvl
		|=> div_out_r != $past(force_hi)) else $error("force acted while bypassed");
	a_start_level: assert property (free_run && state_r == CCD_HOLD
		|=> div_out_r == $past(start_hi) && state_r != CCD_HOLD) else $error("bad start");
	a_phase_wait: assert property (free_run && state_r == CCD_PHASE && in_rise && cnt_r != CW'(phase - 1'b1)
		|=> state_r == CCD_PHASE && $stable(div_out_r)) else $error("phase offset cut short");

	c_run_toggle: cover property (free_run && state_r == CCD_RUN && in_rise ##1 $changed(div_out_r));
	c_phase_done: cover property (state_r == CCD_PHASE ##1 state_r == CCD_RUN);
	c_sync_release: cover property (sync_act && !ignore_sync ##1 !sync_act);
endmodule : ccd_div_core

// *** ccd_top.sv ***
module ccd_top (
	input wire logic clk_sys, // System clock, 40 MHz
	input wire logic rstn, // Async reset, active low
	input wire logic reg_we, // Register write strobe
	input wire logic reg_re, // Register read strobe
	input wire logic [ccd_pkg::AW-1:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Register write data
	output logic [7:0] reg_rdata_r, // Register read data, one cycle after read
	input wire logic src_clk, // Divider input clock level
	input wire logic sync_act, // Chip-level sync, active high
	output logic div1_out_r, // Divider one output
	output logic div2_out_r, // Divider two output
	output logic [ccd_pkg::CH_OUTS-1:0] ch1_out_en_r, // Channel one output enables
	output logic ch1_dcc_on_r // Duty-cycle correction active
);
	logic [7:0] d1_cnt_r, d1_cnt_nxt;
	logic [7:0] d1_ctrl_r, d1_ctrl_nxt;
	logic [7:0] ch1_cfg_r, ch1_cfg_nxt;
	logic [7:0] d2_cnt_r, d2_cnt_nxt;
	logic [7:0] d2_ctrl_r, d2_ctrl_nxt;
	logic [7:0] rdata_nxt;
	logic [ccd_pkg::CH_OUTS-1:0] en_nxt;
	logic dcc_nxt;
	logic src_prev_r;
	wire logic in_rise = src_clk && !src_prev_r;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Write decode and read mux; unmapped reads give zero
	always_comb begin
		d1_cnt_nxt = d1_cnt_r;
		d1_ctrl_nxt = d1_ctrl_r;
		ch1_cfg_nxt = ch1_cfg_r;
		d2_cnt_nxt = d2_cnt_r;
		d2_ctrl_nxt = d2_ctrl_r;
		rdata_nxt = reg_rdata_r;
		if (reg_we) begin
			case (reg_addr)
				ccd_pkg::OFS_D1_CNT: d1_cnt_nxt = reg_wdata;
				ccd_pkg::OFS_D1_CTRL: d1_ctrl_nxt = reg_wdata;
				ccd_pkg::OFS_CH1_CFG: ch1_cfg_nxt = reg_wdata & ccd_pkg::CH_CFG_MASK;
				ccd_pkg::OFS_D2_CNT: d2_cnt_nxt = reg_wdata;
				ccd_pkg::OFS_D2_CTRL: d2_ctrl_nxt = reg_wdata;
				default: ;
			endcase
		end
		if (reg_re) begin
			case (reg_addr)
				ccd_pkg::OFS_D1_CNT: rdata_nxt = d1_cnt_r;
				ccd_pkg::OFS_D1_CTRL: rdata_nxt = d1_ctrl_r;
				ccd_pkg::OFS_CH1_CFG: rdata_nxt = ch1_cfg_r;
				ccd_pkg::OFS_D2_CNT: rdata_nxt = d2_cnt_r;
				ccd_pkg::OFS_D2_CTRL: rdata_nxt = d2_ctrl_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Channel outputs follow the channel register and the divider one bypass bit
	always_comb begin
		en_nxt = ch1_cfg_r[ccd_pkg::PD_BIT] ? '0 : '1;
		dcc_nxt = !ch1_cfg_r[ccd_pkg::DCC_BIT] && !d1_ctrl_r[ccd_pkg::BYP_BIT];
	end

	// Register updates
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			d1_cnt_r <= ccd_pkg::RST_D1_CNT;
			d1_ctrl_r <= ccd_pkg::RST_D1_CTRL;
			ch1_cfg_r <= ccd_pkg::RST_CH1_CFG;
			d2_cnt_r <= ccd_pkg::RST_D2_CNT;
			d2_ctrl_r <= ccd_pkg::RST_D2_CTRL;
			reg_rdata_r <= 8'h00;
			ch1_out_en_r <= '1;
			ch1_dcc_on_r <= 1'b1;
			src_prev_r <= 1'b0;
		end else begin
			d1_cnt_r <= d1_cnt_nxt;
			d1_ctrl_r <= d1_ctrl_nxt;
			ch1_cfg_r <= ch1_cfg_nxt;
			d2_cnt_r <= d2_cnt_nxt;
			d2_ctrl_r <= d2_ctrl_nxt;
			reg_rdata_r <= rdata_nxt;
			ch1_out_en_r <= en_nxt;
			ch1_dcc_on_r <= dcc_nxt;
			src_prev_r <= src_clk;
		end
	end

	// ------------------------------------------------------------
	// Dividers
	// ------------------------------------------------------------
	ccd_div_core #(.CW(4)) u_div1 (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.in_rise(in_rise),
		.src_lvl(src_clk),
		.low_cnt(d1_cnt_r[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB]),
		.high_cnt(d1_cnt_r[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB]),
		.phase(d1_ctrl_r[ccd_pkg::PH_MSB:ccd_pkg::PH_LSB]),
		.bypass(d1_ctrl_r[ccd_pkg::BYP_BIT]),
		.ignore_sync(d1_ctrl_r[ccd_pkg::IGN_BIT]),
		.force_hi(d1_ctrl_r[ccd_pkg::FRC_BIT]),
		.start_hi(d1_ctrl_r[ccd_pkg::STH_BIT]),
		.sync_act(sync_act),
		.div_out_r(div1_out_r)
	);

	ccd_div_core #(.CW(4)) u_div2 (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.in_rise(in_rise),
		.src_lvl(src_clk),
		.low_cnt(d2_cnt_r[ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB]),
		.high_cnt(d2_cnt_r[ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB]),
		.phase(d2_ctrl_r[ccd_pkg::PH_MSB:ccd_pkg::PH_LSB]),
		.bypass(d2_ctrl_r[ccd_pkg::BYP_BIT]),
		.ignore_sync(d2_ctrl_r[ccd_pkg::IGN_BIT]),
		.force_hi(d2_ctrl_r[ccd_pkg::FRC_BIT]),
		.start_hi(d2_ctrl_r[ccd_pkg::STH_BIT]),
		.sync_act(sync_act),
		.div_out_r(div2_out_r)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_phase_field: assert property (reg_we && reg_addr == ccd_pkg::OFS_D1_CTRL
		|=> d1_ctrl_r[ccd_pkg::PH_MSB:ccd_pkg::PH_LSB] == $past(reg_wdata[ccd_pkg::PH_MSB:ccd_pkg::PH_LSB]))
		else $error("phase field not stored");
	a_power_down: assert property (ch1_cfg_r[ccd_pkg::PD_BIT] && $stable(ch1_cfg_r) |=> ch1_out_en_r == '0)
		else $error("channel not powered down");
	a_dcc_state: assert property ($stable(ch1_cfg_r) && $stable(d1_ctrl_r)
		|=> ch1_dcc_on_r == !($past(ch1_cfg_r[ccd_pkg::DCC_BIT]) || $past(d1_ctrl_r[ccd_pkg::BYP_BIT])))
		else $error("duty-cycle correction state wrong");
	// Only the power-down and correction bits of the channel register may ever be set
	a_cfg_mask: assert property ((ch1_cfg_r & ~ccd_pkg::CH_CFG_MASK) == 8'h00)
		else $error("channel register holds unused bits");

	c_power_down: cover property (ch1_out_en_r == '1 ##1 ch1_out_en_r == '0);
	c_bypass_on: cover property (d1_ctrl_r[ccd_pkg::BYP_BIT] && $changed(div1_out_r));
endmodule : ccd_top

// *** channel_clock_divider_tb.sv ***
module channel_clock_divider_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Bench signals and design instance
	// ------------------------------------------------------------
	logic clk_sys = 0, rstn = 0, reg_we = 0, reg_re = 0, src_clk = 0, sync_act = 0;
	logic [ccd_pkg::AW-1:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0, reg_rdata_r, rd, v;
	logic div1_out_r, div2_out_r, ch1_dcc_on_r;
	logic [ccd_pkg::CH_OUTS-1:0] ch1_out_en_r;
	logic [3:0] p;
	int num_errors = 0, checks = 0, cyc = 0, hi, lo, d0, dp;
	logic [ccd_pkg::AW-1:0] addrs [5] = '{ccd_pkg::OFS_D1_CNT, ccd_pkg::OFS_D1_CTRL,
		ccd_pkg::OFS_CH1_CFG, ccd_pkg::OFS_D2_CNT, ccd_pkg::OFS_D2_CTRL};
	logic [7:0] rsts [5] = '{ccd_pkg::RST_D1_CNT, ccd_pkg::RST_D1_CTRL, ccd_pkg::RST_CH1_CFG,
		ccd_pkg::RST_D2_CNT, ccd_pkg::RST_D2_CTRL};

	ccd_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_we(reg_we), .reg_re(reg_re),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .src_clk(src_clk),
		.sync_act(sync_act), .div1_out_r(div1_out_r), .div2_out_r(div2_out_r),
		.ch1_out_en_r(ch1_out_en_r), .ch1_dcc_on_r(ch1_dcc_on_r));

	// Clock, divider input at half the system rate, and hang limit
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) src_clk <= #2 ~src_clk;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			conclude();
		end
	end
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [ccd_pkg::AW-1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#2 reg_we = 1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk_sys);
		#2 reg_we = 0;
	endtask : wr

	task automatic rdr(input logic [ccd_pkg::AW-1:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#2 reg_re = 1;
		reg_addr = a;
		@(posedge clk_sys);
		#2 reg_re = 0;
		d = reg_rdata_r;
	endtask : rdr

	// Settle a few edges, then sample just after an edge
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : settle

	// Time one full high and one full low level of a divider output
	task automatic measure(input bit sel, output int h, output int l);
		int n;
		n = 0;
		h = 0;
		l = 0;
		while ((sel ? div2_out_r : div1_out_r) !== 1'b0 && n < 300) begin @(posedge clk_sys); #1 n++; end
		while ((sel ? div2_out_r : div1_out_r) !== 1'b1 && n < 300) begin @(posedge clk_sys); #1 n++; end
		while ((sel ? div2_out_r : div1_out_r) === 1'b1 && n < 300) begin @(posedge clk_sys); #1 n++; h++; end
		while ((sel ? div2_out_r : div1_out_r) === 1'b0 && n < 300) begin @(posedge clk_sys); #1 n++; l++; end
		if (n >= 300) check("divider toggling", 16'h0, 16'h1);
	endtask : measure

	// Hold sync, release it at a fixed input phase, count cycles to the first edge
	task automatic start_delay(input logic st, output int n);
		@(posedge clk_sys);
		#2 sync_act = 1;
		settle();
		check("sync hold level", div2_out_r, st);
		while (src_clk !== 1'b0) begin @(posedge clk_sys); #1; end
		#1 sync_act = 0;
		n = 0;
		while (div2_out_r === st && n < 300) begin @(posedge clk_sys); #1 n++; end
	endtask : start_delay

	task automatic conclude();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(66));
		repeat (12) @(posedge clk_sys);
		#2 rstn = 1;
		// Reset values, unmapped place, random write and read back
		for (int i = 0; i < 5; i++) begin
			rdr(addrs[i], rd);
			check("reset value", rd, rsts[i]);
		end
		check("enables after reset", ch1_out_en_r, 3'h7);
		check("correction after reset", ch1_dcc_on_r, 1'b1);
		wr(10'h198, 8'hff);
		rdr(10'h198, rd);
		check("unmapped read", rd, 8'h00);
		for (int i = 0; i < 5; i++) begin
			v = 8'($urandom);
			wr(addrs[i], v);
			rdr(addrs[i], rd);
			check("register rw", rd, (i == 2) ? (v & ccd_pkg::CH_CFG_MASK) : v);
		end
		wr(ccd_pkg::OFS_D1_CTRL, 8'h00);
		wr(ccd_pkg::OFS_CH1_CFG, 8'h00);
		wr(ccd_pkg::OFS_D2_CTRL, 8'h00);
		$display("test registers done");
		// Low and high counts, corner values then random ones
		wr(ccd_pkg::OFS_D1_CNT, 8'h33);
		measure(0, hi, lo);
		check("div1 high", hi, 16'd8);
		check("div1 low", lo, 16'd8);
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
			wr(ccd_pkg::OFS_D2_CNT, v);
			measure(1, hi, lo);
			check("div2 high", hi, 2 * (v[3:0] + 1));
			check("div2 low", lo, 2 * (v[7:4] + 1));
		end
		$display("test counts done");
		// Start level and phase offset after sync release
		wr(ccd_pkg::OFS_D2_CNT, 8'h11);
		wr(ccd_pkg::OFS_D2_CTRL, 8'h00);
		start_delay(1'b0, d0);
		for (int k = 0; k < 3; k++) begin
			p = (k == 0) ? 4'hf : 4'($urandom);
			wr(ccd_pkg::OFS_D2_CTRL, {4'h0, p});
			start_delay(1'b0, dp);
			check("phase delay", dp - d0, 2 * p);
		end
		wr(ccd_pkg::OFS_D2_CTRL, 8'h10);
		start_delay(1'b1, dp);
		check("start high delay", dp, d0);
		$display("test sync and phase done");
		// Ignore-sync with forced levels, force alone, then bypass
		for (int f = 0; f < 2; f++) begin
			wr(ccd_pkg::OFS_D2_CTRL, f[0] ? 8'h60 : 8'h40);
			settle();
			repeat (12) begin
				check("forced level", div2_out_r, f[0]);
				#1 sync_act = 1'($urandom);
				@(posedge clk_sys);
				#1;
			end
		end
		#1 sync_act = 0;
		wr(ccd_pkg::OFS_D2_CTRL, 8'h20);
		measure(1, hi, lo);
		check("force without ignore", hi, 16'd4);
		wr(ccd_pkg::OFS_D2_CTRL, 8'he0);
		settle();
		repeat (10) begin
			check("bypass output", div2_out_r, src_clk);
			@(posedge clk_sys);
			#1;
		end
		$display("test force and bypass done");
		// Channel power-down and duty-cycle correction
		wr(ccd_pkg::OFS_CH1_CFG, 8'h04);
		settle();
		check("powered down", ch1_out_en_r, 3'h0);
		check("correction kept", ch1_dcc_on_r, 1'b1);
		wr(ccd_pkg::OFS_CH1_CFG, 8'h01);
		settle();
		check("powered up", ch1_out_en_r, 3'h7);
		check("correction off", ch1_dcc_on_r, 1'b0);
		wr(ccd_pkg::OFS_CH1_CFG, 8'h00);
		wr(ccd_pkg::OFS_D1_CTRL, 8'h80);
		settle();
		check("correction bypassed", ch1_dcc_on_r, 1'b0);
		wr(ccd_pkg::OFS_D1_CTRL, 8'h00);
		settle();
		check("correction on", ch1_dcc_on_r, 1'b1);
		$display("test channel done");
		conclude();
	end
endmodule : channel_clock_divider_tb
